// ===== rtl/afepw_pkg.sv
// constants and carrier types for the analog front-end power register bank
package afepw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register addresses on the memory bus
    localparam logic [19:0] AFEPW_SELECT_ADDR = 20'hF_0440;
    localparam logic [19:0] AFEPW_DETECT_ADDR = 20'hF_0441;

    ////////////////////////////////////////////////////////////////////////////
    // field positions of the selection register
    localparam int AFEPW_SEL_DAC_BIT = 7;
    localparam int AFEPW_SEL_AMP2_BIT = 6;
    localparam int AFEPW_SEL_AMP1_BIT = 5;
    localparam int AFEPW_SEL_AMP0_BIT = 4;
    localparam int AFEPW_SEL_RSV3_BIT = 3;
    localparam int AFEPW_SEL_GAIN_BIT = 2;
    localparam int AFEPW_SEL_RSV1_BIT = 1;
    localparam int AFEPW_SEL_REF_BIT = 0;

    // field positions of the detection register
    localparam int AFEPW_DET_GAIN_BIT = 2;
    localparam int AFEPW_DET_REF_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and masks
    localparam logic [7:0] AFEPW_SELECT_RESET = 8'h00;
    localparam logic [7:0] AFEPW_DETECT_RESET = 8'h00;
    localparam logic [7:0] AFEPW_SELECT_WMASK = 8'hF5;
    localparam logic [7:0] AFEPW_DETECT_RMASK = 8'h05;
    localparam logic [7:0] AFEPW_RDATA_RESET = 8'h00;

    // synchroniser depth for the analog settling indications
    localparam int AFEPW_SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////
    // one memory-instruction access as seen by the register bank
    typedef struct packed {
        logic wr;
        logic rd;
        logic bit_op;
        logic [2:0] bit_sel;
        logic [19:0] addr;
        logic [7:0] wdata;
    } afepw_sfr_req_s;

    // selection register layout, msb first
    typedef struct packed {
        logic dac;
        logic amp2;
        logic amp1;
        logic amp0;
        logic rsv3;
        logic gain;
        logic rsv1;
        logic ref_sup;
    } afepw_select_s;

    // whole state of the register bank
    typedef struct packed {
        afepw_select_s sel;
        logic [7:0] rdata;
        logic rbit;
        logic rvalid;
    } afepw_regs_state_s;

endpackage : afepw_pkg

// ===== rtl/afepw_stable_flag.sv
// supply stabilized flag: synchronises settling indications and gates them with the enable
module afepw_stable_flag #(
    parameter int NUM_SRC = 1
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_enable,
    input wire logic [NUM_SRC-1:0] i_settle_async,
    output logic o_stable
);
    import afepw_pkg::*;

    typedef struct packed {
        logic [NUM_SRC-1:0] sync1;
        logic [NUM_SRC-1:0] sync2;
        logic stable;
    } afepw_flag_state_s;

    afepw_flag_state_s st_ff;
    afepw_flag_state_s nxt_st;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync1 = i_settle_async;
        nxt_st.sync2 = st_ff.sync1;
        // every source must have settled; removing the enable drops the flag on the next clock edge
        nxt_st.stable = i_enable && (&st_ff.sync2);
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign o_stable = st_ff.stable;

    ////////////////////////////////////////////////////////////////////////////
    property p_flag_needs_all_settled;
        @(posedge i_clk) disable iff (i_srst)
        $rose(o_stable) |-> ($past(&st_ff.sync2) && $past(i_enable));
    endproperty
    a_flag_needs_all_settled: assert property (p_flag_needs_all_settled)
        else $error("stable flag rose without all settling indications");

    property p_flag_drops_with_enable;
        @(posedge i_clk) disable iff (i_srst)
        !i_enable |=> !o_stable;
    endproperty
    a_flag_drops_with_enable: assert property (p_flag_drops_with_enable)
        else $error("stable flag held after enable removed");

endmodule : afepw_stable_flag

// ===== rtl/afepw_power_regs.sv
// analog front-end power selection and detection register bank
module afepw_power_regs (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_front_end_clock_enable,
    input wire afepw_pkg::afepw_sfr_req_s i_req,
    input wire logic i_bandgap_settled,
    input wire logic i_internal_regulator_settled,
    input wire logic i_sensor_bias_settled,
    output logic [7:0] o_rdata,
    output logic o_rbit,
    output logic o_rvalid,
    output logic o_dac_power_enable,
    output logic o_amp_two_power_enable,
    output logic o_amp_one_power_enable,
    output logic o_amp_zero_power_enable,
    output logic o_gain_amp_power_enable,
    output logic o_reference_supply_enable,
    output logic o_reference_supply_stable,
    output logic o_gain_amp_supply_stable
);
    import afepw_pkg::*;

    afepw_regs_state_s st_ff;
    afepw_regs_state_s nxt_st;

    logic ref_flag_enable;
    logic gain_flag_enable;
    logic ref_stable;
    logic gain_stable;
    logic [7:0] detect_byte;

    ////////////////////////////////////////////////////////////////////////////
    // stabilized flags; the clock enable is folded in so a block reset clears them
    // without waiting for the selection register to follow
    assign ref_flag_enable = st_ff.sel.ref_sup && i_front_end_clock_enable;
    assign gain_flag_enable = st_ff.sel.ref_sup && st_ff.sel.gain && i_front_end_clock_enable;

    afepw_stable_flag #(
        .NUM_SRC(1)
    ) u_ref_flag (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_enable(ref_flag_enable),
        .i_settle_async(i_bandgap_settled),
        .o_stable(ref_stable)
    );

    // the gain amp supply is only good when both regulators report settled
    afepw_stable_flag #(
        .NUM_SRC(2)
    ) u_gain_flag (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_enable(gain_flag_enable),
        .i_settle_async({i_internal_regulator_settled, i_sensor_bias_settled}),
        .o_stable(gain_stable)
    );

    always_comb begin
        detect_byte = AFEPW_DETECT_RESET;
        detect_byte[AFEPW_DET_REF_BIT] = ref_stable;
        detect_byte[AFEPW_DET_GAIN_BIT] = gain_stable;
        detect_byte = detect_byte & AFEPW_DETECT_RMASK;
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [7:0] sel_byte;
        logic [7:0] rd_byte;
        logic wr_select;
        sel_byte = st_ff.sel;
        rd_byte = AFEPW_RDATA_RESET;
        wr_select = i_req.wr && (i_req.addr == AFEPW_SELECT_ADDR);
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;

        // bit writes are read-modify-write of the current contents
        if (wr_select && i_front_end_clock_enable) begin
            if (i_req.bit_op) begin
                sel_byte[i_req.bit_sel] = i_req.wdata[0];
            end else begin
                sel_byte = i_req.wdata;
            end
        end
        // reserved positions never store a one even if software breaks the convention
        nxt_st.sel = afepw_select_s'(sel_byte & AFEPW_SELECT_WMASK);
        if (!i_front_end_clock_enable) begin
            nxt_st.sel = afepw_select_s'(AFEPW_SELECT_RESET);
        end

        // a read in the same cycle as a write returns the old contents
        if (i_req.rd) begin
            case (i_req.addr)
                AFEPW_SELECT_ADDR: begin
                    rd_byte = st_ff.sel & AFEPW_SELECT_WMASK;
                end
                AFEPW_DETECT_ADDR: begin
                    rd_byte = detect_byte;
                end
                default: begin
                    rd_byte = AFEPW_RDATA_RESET;
                end
            endcase
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata = rd_byte;
            nxt_st.rbit = rd_byte[i_req.bit_sel];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_ff.sel <= afepw_select_s'(AFEPW_SELECT_RESET);
            st_ff.rdata <= AFEPW_RDATA_RESET;
            st_ff.rbit <= 1'b0;
            st_ff.rvalid <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // power controls go straight from the register to the analog supplies
    assign o_dac_power_enable = st_ff.sel.dac;
    assign o_amp_two_power_enable = st_ff.sel.amp2;
    assign o_amp_one_power_enable = st_ff.sel.amp1;
    assign o_amp_zero_power_enable = st_ff.sel.amp0;
    assign o_gain_amp_power_enable = st_ff.sel.gain;
    assign o_reference_supply_enable = st_ff.sel.ref_sup;
    assign o_reference_supply_stable = ref_stable;
    assign o_gain_amp_supply_stable = gain_stable;
    assign o_rdata = st_ff.rdata;
    assign o_rbit = st_ff.rbit;
    assign o_rvalid = st_ff.rvalid;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    property p_byte_write_stores;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && !i_req.bit_op && i_req.addr == AFEPW_SELECT_ADDR && i_front_end_clock_enable)
            ##1 i_front_end_clock_enable
        |-> (st_ff.sel == ($past(i_req.wdata, 1) & AFEPW_SELECT_WMASK));
    endproperty
    a_byte_write_stores: assert property (p_byte_write_stores)
        else $error("byte write not stored in selection register");

    property p_byte_readback;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && !i_req.bit_op && i_req.addr == AFEPW_SELECT_ADDR && i_front_end_clock_enable)
            ##1 (i_front_end_clock_enable && !i_req.wr && i_req.rd && i_req.addr == AFEPW_SELECT_ADDR)
        |=> o_rvalid && (o_rdata == ($past(i_req.wdata, 2) & AFEPW_SELECT_WMASK));
    endproperty
    a_byte_readback: assert property (p_byte_readback)
        else $error("selection register read back differs from byte written");

    property p_bit_write_one_bit;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && i_req.bit_op && i_req.addr == AFEPW_SELECT_ADDR && i_front_end_clock_enable)
        |=> ((st_ff.sel ^ $past(st_ff.sel)) & ~(8'h01 << $past(i_req.bit_sel))) == 8'h00;
    endproperty
    a_bit_write_one_bit: assert property (p_bit_write_one_bit)
        else $error("bit write disturbed other selection bits");

    property p_reset_clears;
        @(posedge i_clk)
        $fell(i_srst) |-> (st_ff.sel == AFEPW_SELECT_RESET) && !o_reference_supply_stable
            && !o_gain_amp_supply_stable && !o_rvalid;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("selection register not clear after reset");

    property p_byte_write_drives;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && !i_req.bit_op && i_req.addr == AFEPW_SELECT_ADDR && i_front_end_clock_enable)
        |=> (o_dac_power_enable == $past(i_req.wdata[AFEPW_SEL_DAC_BIT]))
            && (o_amp_zero_power_enable == $past(i_req.wdata[AFEPW_SEL_AMP0_BIT]))
            && (o_gain_amp_power_enable == $past(i_req.wdata[AFEPW_SEL_GAIN_BIT]));
    endproperty
    a_byte_write_drives: assert property (p_byte_write_drives)
        else $error("dac, amp0 or gain amp enable does not follow byte write");

    property p_amp_two_bit;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && i_req.bit_op && i_req.bit_sel == 3'(AFEPW_SEL_AMP2_BIT)
            && i_req.addr == AFEPW_SELECT_ADDR && i_front_end_clock_enable)
        |=> o_amp_two_power_enable == $past(i_req.wdata[0]);
    endproperty
    a_amp_two_bit: assert property (p_amp_two_bit)
        else $error("amp two enable does not follow bit write");

    property p_amp_one_bit;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && i_req.bit_op && i_req.bit_sel == 3'(AFEPW_SEL_AMP1_BIT)
            && i_req.addr == AFEPW_SELECT_ADDR && i_front_end_clock_enable)
        |=> o_amp_one_power_enable == $past(i_req.wdata[0]);
    endproperty
    a_amp_one_bit: assert property (p_amp_one_bit)
        else $error("amp one enable does not follow bit write");

    property p_ref_bit;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && i_req.bit_op && i_req.bit_sel == 3'(AFEPW_SEL_REF_BIT)
            && i_req.addr == AFEPW_SELECT_ADDR && i_front_end_clock_enable)
        |=> o_reference_supply_enable == $past(i_req.wdata[0]);
    endproperty
    a_ref_bit: assert property (p_ref_bit)
        else $error("reference supply enable does not follow bit write");

    property p_reserved_read_zero;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.rd && i_req.addr == AFEPW_SELECT_ADDR)
        |=> o_rvalid && !o_rdata[AFEPW_SEL_RSV1_BIT] && !o_rdata[AFEPW_SEL_RSV3_BIT];
    endproperty
    a_reserved_read_zero: assert property (p_reserved_read_zero)
        else $error("reserved selection bit read as one");

    property p_detect_unused_zero;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.rd && i_req.addr == AFEPW_DETECT_ADDR)
        |=> o_rvalid && ((o_rdata & ~AFEPW_DETECT_RMASK) == 8'h00);
    endproperty
    a_detect_unused_zero: assert property (p_detect_unused_zero)
        else $error("unused detection bit read as one");

    property p_detect_ref_read;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.rd && i_req.addr == AFEPW_DETECT_ADDR)
        |=> o_rdata[AFEPW_DET_REF_BIT] == $past(o_reference_supply_stable);
    endproperty
    a_detect_ref_read: assert property (p_detect_ref_read)
        else $error("detection bit 0 differs from reference stable flag");

    property p_detect_gain_read;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.rd && i_req.addr == AFEPW_DETECT_ADDR)
        |=> o_rdata[AFEPW_DET_GAIN_BIT] == $past(o_gain_amp_supply_stable);
    endproperty
    a_detect_gain_read: assert property (p_detect_gain_read)
        else $error("detection bit 2 differs from gain amp stable flag");

    property p_gain_needs_both;
        @(posedge i_clk) disable iff (i_srst)
        $rose(o_gain_amp_supply_stable) |-> $past(i_internal_regulator_settled, 3)
            && $past(i_sensor_bias_settled, 3);
    endproperty
    a_gain_needs_both: assert property (p_gain_needs_both)
        else $error("gain amp stable rose without both regulators settled");

    property p_clock_gate_clears;
        @(posedge i_clk) disable iff (i_srst)
        !i_front_end_clock_enable |=> (st_ff.sel == AFEPW_SELECT_RESET)
            ##1 (!o_reference_supply_stable && !o_gain_amp_supply_stable);
    endproperty
    a_clock_gate_clears: assert property (p_clock_gate_clears)
        else $error("enables survive clock enable low");

    property p_flag_follows_enable;
        @(posedge i_clk) disable iff (i_srst)
        o_gain_amp_supply_stable |-> $past(o_gain_amp_power_enable) && $past(o_reference_supply_enable);
    endproperty
    a_flag_follows_enable: assert property (p_flag_follows_enable)
        else $error("gain amp stable set without its enables");

    property p_ref_flag_clears;
        @(posedge i_clk) disable iff (i_srst)
        $fell(o_reference_supply_enable) |=> !o_reference_supply_stable;
    endproperty
    a_ref_flag_clears: assert property (p_ref_flag_clears)
        else $error("reference stable held after enable removed");

    // guarded so a read strobe held through reset cannot fire it on release
    property p_rvalid_follows_read;
        @(posedge i_clk) disable iff (i_srst)
        !$past(i_srst) |-> o_rvalid == $past(i_req.rd);
    endproperty
    a_rvalid_follows_read: assert property (p_rvalid_follows_read)
        else $error("read valid pulse not one cycle after read strobe");

    property p_detect_write_ignored;
        @(posedge i_clk) disable iff (i_srst)
        (i_req.wr && i_req.addr == AFEPW_DETECT_ADDR && i_front_end_clock_enable)
        |=> st_ff.sel == $past(st_ff.sel);
    endproperty
    a_detect_write_ignored: assert property (p_detect_write_ignored)
        else $error("write to detection register changed the selection register");

    property p_clock_gate_drops_flags;
        @(posedge i_clk) disable iff (i_srst)
        !i_front_end_clock_enable |=> !o_reference_supply_stable && !o_gain_amp_supply_stable;
    endproperty
    a_clock_gate_drops_flags: assert property (p_clock_gate_drops_flags)
        else $error("stable flags survive clock enable low");

    property p_ref_needs_settle;
        @(posedge i_clk) disable iff (i_srst)
        $rose(o_reference_supply_stable) |-> $past(i_bandgap_settled, 3) && $past(o_reference_supply_enable);
    endproperty
    a_ref_needs_settle: assert property (p_ref_needs_settle)
        else $error("reference stable rose without settling or enable");

endmodule : afepw_power_regs

// ===== verification/analog_front_power_regs_tb_top.sv
// self-checking bench for the analog front-end power register bank
module analog_front_power_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import afepw_pkg::*;

    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic i_front_end_clock_enable = 1'b1;
    afepw_sfr_req_s i_req = '0;
    logic i_bandgap_settled = 1'b0;
    logic i_internal_regulator_settled = 1'b0;
    logic i_sensor_bias_settled = 1'b0;
    logic [7:0] o_rdata;
    logic o_rbit;
    logic o_rvalid;
    logic o_dac_power_enable;
    logic o_amp_two_power_enable;
    logic o_amp_one_power_enable;
    logic o_amp_zero_power_enable;
    logic o_gain_amp_power_enable;
    logic o_reference_supply_enable;
    logic o_reference_supply_stable;
    logic o_gain_amp_supply_stable;
    int err_total = 0;
    int checked = 0;
    // each note: use-bit flag, expected bit, expected byte
    logic [9:0] exp_q[$];
    logic [9:0] note;
    logic [7:0] acc;
    logic [7:0] d;

    always #25 i_clk = ~i_clk;

    afepw_power_regs u_afepw_power_regs (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_front_end_clock_enable(i_front_end_clock_enable),
        .i_req(i_req),
        .i_bandgap_settled(i_bandgap_settled),
        .i_internal_regulator_settled(i_internal_regulator_settled),
        .i_sensor_bias_settled(i_sensor_bias_settled),
        .o_rdata(o_rdata),
        .o_rbit(o_rbit),
        .o_rvalid(o_rvalid),
        .o_dac_power_enable(o_dac_power_enable),
        .o_amp_two_power_enable(o_amp_two_power_enable),
        .o_amp_one_power_enable(o_amp_one_power_enable),
        .o_amp_zero_power_enable(o_amp_zero_power_enable),
        .o_gain_amp_power_enable(o_gain_amp_power_enable),
        .o_reference_supply_enable(o_reference_supply_enable),
        .o_reference_supply_stable(o_reference_supply_stable),
        .o_gain_amp_supply_stable(o_gain_amp_supply_stable)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    // every task is entered 1 ns after a rising edge and returns the same way
    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : idle

    // request order: wr, rd, bit_op, bit_sel, addr, wdata; the whole request changes in one assignment
    task automatic wr(input logic [19:0] a, input logic b, input logic [2:0] s, input logic [7:0] v);
        i_req = {1'b1, 1'b0, b, s, a, v};
        idle(1);
        // drop the strobe and let an edge pass so the next request starts from idle
        i_req = '0;
        idle(1);
    endtask : wr

    task automatic rd(input logic [19:0] a, input logic b, input logic [2:0] s, input logic [7:0] e);
        i_req = {1'b0, 1'b1, b, s, a, 8'h00};
        exp_q.push_back({b, e[s], e});
        idle(1);
        i_req = '0;
        idle(1);
    endtask : rd

    // byte write and a read of the same register in the very next cycle
    task automatic wr_rd(input logic [19:0] a, input logic [7:0] v, input logic [7:0] e);
        i_req = {1'b1, 1'b0, 1'b0, 3'd0, a, v};
        idle(1);
        i_req = {1'b0, 1'b1, 1'b0, 3'd0, a, 8'h00};
        exp_q.push_back({1'b0, e[0], e});
        chk_en(e);
        idle(1);
        i_req = '0;
        idle(1);
    endtask : wr_rd

    task automatic chk_en(input logic [7:0] e);
        chk({o_dac_power_enable, o_amp_two_power_enable, o_amp_one_power_enable, o_amp_zero_power_enable,
             1'b0, o_gain_amp_power_enable, 1'b0, o_reference_supply_enable}, e);
    endtask : chk_en

    function automatic logic flag(input int w);
        return (w != 0) ? o_gain_amp_supply_stable : o_reference_supply_stable;
    endfunction : flag

    // settling goes through synchronisers, so allow a short bounded wait
    task automatic wait_flag(input int w, input logic v);
        int n;
        n = 0;
        while (flag(w) !== v && n < 12) begin
            idle(1);
            n++;
        end
        chk({7'h00, flag(w)}, {7'h00, v});
    endtask : wait_flag

    ////////////////////////////////////////////////////////////////////////////
    // read monitor: sampled mid-cycle so the registered answer has settled
    always @(negedge i_clk) begin
        if (o_rvalid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk({7'h00, o_rvalid}, 8'h00);
            end else begin
                note = exp_q.pop_front();
                chk(o_rdata, note[7:0]);
                if (note[9]) begin
                    chk({7'h00, o_rbit}, {7'h00, note[8]});
                end
            end
        end
    end

    initial begin
        repeat (4000) @(posedge i_clk);
        err_total++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(41));
        repeat (20) @(posedge i_clk);
        #1;
        i_srst = 1'b0;
        chk_en(8'h00);
        chk({6'h00, o_gain_amp_supply_stable, o_reference_supply_stable}, 8'h00);
        rd(AFEPW_SELECT_ADDR, 1'b0, 3'd0, AFEPW_SELECT_RESET);
        rd(AFEPW_DETECT_ADDR, 1'b0, 3'd0, AFEPW_DETECT_RESET);
        // every enable on; software keeps the reserved positions at zero
        wr(AFEPW_SELECT_ADDR, 1'b0, 3'd0, AFEPW_SELECT_WMASK);
        chk_en(8'hF5);
        rd(AFEPW_SELECT_ADDR, 1'b0, 3'd0, 8'hF5);
        wr(AFEPW_SELECT_ADDR, 1'b0, 3'd0, 8'h00);
        chk_en(8'h00);
        acc = 8'h00;
        for (int i = 0; i < 8; i++) begin
            wr(AFEPW_SELECT_ADDR, 1'b1, i[2:0], {7'h00, AFEPW_SELECT_WMASK[i]});
            acc[i] = AFEPW_SELECT_WMASK[i];
            chk_en(acc);
            rd(AFEPW_SELECT_ADDR, 1'b1, i[2:0], acc);
        end
        // only wdata bit 0 counts in a bit write
        for (int i = 0; i < 8; i++) begin
            wr(AFEPW_SELECT_ADDR, 1'b1, i[2:0], 8'hFE);
            acc[i] = 1'b0;
            chk_en(acc);
        end
        wr(AFEPW_DETECT_ADDR, 1'b0, 3'd0, 8'hFF);
        wr(20'hF_0442, 1'b0, 3'd0, 8'hFF);
        chk_en(8'h00);
        rd(AFEPW_DETECT_ADDR, 1'b0, 3'd0, 8'h00);
        rd(20'hF_0442, 1'b0, 3'd0, 8'h00);
        // supplies settling
        wr(AFEPW_SELECT_ADDR, 1'b0, 3'd0, 8'h05);
        i_bandgap_settled = 1'b1;
        i_internal_regulator_settled = 1'b1;
        wait_flag(0, 1'b1);
        idle(6);
        chk({7'h00, o_gain_amp_supply_stable}, 8'h00);
        i_sensor_bias_settled = 1'b1;
        wait_flag(1, 1'b1);
        rd(AFEPW_DETECT_ADDR, 1'b0, 3'd0, 8'h05);
        rd(AFEPW_DETECT_ADDR, 1'b1, 3'd2, 8'h05);
        i_internal_regulator_settled = 1'b0;
        wait_flag(1, 1'b0);
        i_internal_regulator_settled = 1'b1;
        wait_flag(1, 1'b1);
        wr(AFEPW_SELECT_ADDR, 1'b1, 3'd0, 8'h00);
        idle(1);
        chk({6'h00, o_gain_amp_supply_stable, o_reference_supply_stable}, 8'h00);
        rd(AFEPW_DETECT_ADDR, 1'b0, 3'd0, 8'h00);
        i_bandgap_settled = 1'b0;
        wr(AFEPW_SELECT_ADDR, 1'b0, 3'd0, 8'h01);
        idle(6);
        chk({7'h00, o_reference_supply_stable}, 8'h00);
        // clock enable low wipes enables and blocks writes
        wr(AFEPW_SELECT_ADDR, 1'b0, 3'd0, 8'hF5);
        i_bandgap_settled = 1'b1;
        wait_flag(0, 1'b1);
        i_front_end_clock_enable = 1'b0;
        idle(1);
        chk_en(8'h00);
        chk({6'h00, o_gain_amp_supply_stable, o_reference_supply_stable}, 8'h00);
        wr(AFEPW_SELECT_ADDR, 1'b0, 3'd0, AFEPW_SELECT_WMASK);
        chk_en(8'h00);
        rd(AFEPW_SELECT_ADDR, 1'b0, 3'd0, 8'h00);
        i_front_end_clock_enable = 1'b1;
        idle(1);
        rd(AFEPW_SELECT_ADDR, 1'b0, 3'd0, 8'h00);
        // random settings written and read back to back
        for (int i = 0; i < 24; i++) begin
            d = 8'($urandom()) & AFEPW_SELECT_WMASK;
            wr_rd(AFEPW_SELECT_ADDR, d, d);
        end
        idle(4);
        chk(8'(exp_q.size()), 8'h00);
        end_of_test();
    end

endmodule : analog_front_power_regs_tb_top
